// file: logic/ssl_link.sv
// Serial link controller of a byte-wide static memory, device side.
// Assumes the serial clock, select, data in and pause arrive asynchronously
// and are at least several system clocks wide; memory itself lies outside.
`timescale 1ns/1ps

module ssl_link
    import ssl_pkg::*;
(
    input  wire logic               sys_clk_in,
    input  wire logic               reset_in,
    input  wire logic               cs_n_in,
    input  wire logic               sck_in,
    input  wire logic               si_in,
    input  wire logic               pause_n_in,
    output logic                    so_out,
    output logic                    so_oe_out,
    output logic                    standby_out,
    output logic                    paused_out,
    output logic                    rd_req_out,
    output logic [ADDR_W-1:0]       rd_addr_out,
    input  wire logic               rd_valid_in,
    input  wire logic [BYTE_W-1:0]  rd_data_in,
    output logic                    wr_valid_out,
    output ssl_wr_word_t            wr_word_out,
    input  wire logic               wr_ready_in,
    output logic [BYTE_W-1:0]       status_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and edge detection

    ssl_pins_t    s1_q;
    ssl_pins_t    s2_q;
    ssl_pins_t    s3_q;
    ssl_state_t   state_q;
    logic [3:0]   bit_cnt_q;
    logic [2:0]   out_cnt_q;
    logic [7:0]   in_sh_q;
    logic [7:0]   cmd_q;
    logic [15:0]  addr_sh_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0]   rd_byte_q;
    logic [6:0]   out_sh_q;
    logic         paused_q;
    logic         pend_v_q;
    ssl_wr_word_t pend_w_q;
    logic         skid_v_q;
    ssl_wr_word_t skid_w_q;
    logic         sck_rise;
    logic         sck_fall;
    logic         cs_rise;
    logic         act_rise;
    logic         act_fall;
    logic         byte_end;
    logic         wr_take;
    logic         push;
    logic         pop;
    logic [7:0]   byte_nx;
    logic [15:0]  addr_nx;
    logic [7:0]   out_src;

    // Stage one feeds stage two only; edges come from stages two and three
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            s1_q <= PINS_RST;
            s2_q <= PINS_RST;
            s3_q <= PINS_RST;
        end else begin
            s1_q <= '{cs_n: cs_n_in, sck: sck_in, si: si_in, pause_n: pause_n_in};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign sck_rise = s2_q.sck & ~s3_q.sck;
    assign sck_fall = ~s2_q.sck & s3_q.sck;
    assign cs_rise  = s2_q.cs_n & ~s3_q.cs_n;
    // edges ignored while paused, so sequence progress is kept
    assign act_rise = sck_rise & ~s2_q.cs_n & ~paused_q & s2_q.pause_n;
    // a fall with pause low enters pause and is not used for data
    assign act_fall = sck_fall & ~s2_q.cs_n & ~paused_q & s2_q.pause_n;
    // shift in most significant bit first
    assign byte_nx  = {in_sh_q[6:0], s2_q.si};
    assign addr_nx  = {addr_sh_q[14:0], s2_q.si};
    assign byte_end = act_rise & (bit_cnt_q == BYTE_LAST);
    assign wr_take  = byte_end & (state_q == ST_WDAT);
    assign out_src  = (state_q == ST_SRD) ? status_out : rd_byte_q;

    ////////////////////////////////////////////////////////////////////////////
    // Pause control

    // immediate entry with clock low, else deferred to the next fall
    always_ff @(posedge sys_clk_in) begin
        if (reset_in || s2_q.cs_n) begin
            paused_q <= 1'b0;
        end else if (paused_q) begin
            paused_q <= ~(s2_q.pause_n & ~s2_q.sck);
        end else if (~s2_q.pause_n) begin
            paused_q <= ~s2_q.sck | sck_fall;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command sequencer, driven by serial clock edges

    // capture on rise; deselect restarts at instruction byte
    always_ff @(posedge sys_clk_in) begin
        rd_req_out <= 1'b0;
        if (reset_in || cs_rise) begin
            state_q   <= ST_CMD;
            bit_cnt_q <= 4'h0;
            cmd_q     <= 8'h00;
            if (reset_in) begin
                status_out <= STATUS_RST;
            end
        end else if (act_rise) begin
            in_sh_q   <= byte_nx;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            unique case (state_q)
                ST_CMD: begin
                    if (bit_cnt_q == BYTE_LAST) begin
                        bit_cnt_q <= 4'h0;
                        cmd_q     <= byte_nx;
                        if (byte_nx == CMD_MEM_READ || byte_nx == CMD_MEM_WRITE) begin
                            state_q <= ST_ADDR;
                        end else if (byte_nx == status_read_cmd) begin
                            state_q <= ST_SRD;
                        end else if (byte_nx == status_write_cmd) begin
                            state_q <= ST_SWR;
                        end else begin
                            state_q <= ST_SKIP;
                        end
                    end
                end
                ST_ADDR: begin
                    addr_sh_q <= addr_nx;
                    if (bit_cnt_q == ADDR_LAST) begin
                        bit_cnt_q <= 4'h0;
                        addr_q    <= addr_nx[ADDR_W-1:0];
                        if (cmd_q == CMD_MEM_READ) begin
                            state_q     <= ST_RDAT;
                            rd_req_out  <= 1'b1;
                            rd_addr_out <= addr_nx[ADDR_W-1:0];
                        end else begin
                            state_q <= ST_WDAT;
                        end
                    end
                end
                ST_SWR: begin
                    if (bit_cnt_q == BYTE_LAST) begin
                        status_out <= byte_nx;
                        state_q    <= ST_SKIP;
                    end
                end
                ST_WDAT: begin
                    if (wr_take) begin
                        bit_cnt_q <= 4'h0;
                        addr_q    <= addr_q + 15'h0001;
                    end
                end
                ST_RDAT, ST_SRD, ST_SKIP: begin
                    if (byte_end) begin
                        bit_cnt_q <= 4'h0;
                    end
                end
                default: state_q <= ST_CMD;
            endcase
        end else if (act_fall && state_q == ST_RDAT && out_cnt_q == 3'h0) begin
            // Byte just loaded for output; prefetch the next one well before it is due
            addr_q      <= addr_q + 15'h0001;
            rd_req_out  <= 1'b1;
            rd_addr_out <= addr_q + 15'h0001;
        end
    end

    // Fetched byte from the array
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rd_byte_q <= 8'h00;
        end else if (rd_valid_in) begin
            rd_byte_q <= rd_data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial output

    // output bit moves only on a clock fall, and clears to 0 on deselect; MSB leaves first
    always_ff @(posedge sys_clk_in) begin
        if (reset_in || cs_rise) begin
            so_out    <= 1'b0;
            out_sh_q  <= 7'h00;
            out_cnt_q <= 3'h0;
        end else if (act_fall && (state_q == ST_RDAT || state_q == ST_SRD)) begin
            out_cnt_q <= out_cnt_q + 3'h1;
            if (out_cnt_q == 3'h0) begin
                so_out   <= out_src[7];
                out_sh_q <= out_src[6:0];
            end else begin
                so_out   <= out_sh_q[6];
                out_sh_q <= {out_sh_q[5:0], 1'b0};
            end
        end
    end

    // output enable drops with select high or pause low
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            so_oe_out  <= 1'b0;
            paused_out <= 1'b0;
        end else begin
            so_oe_out  <= ~s2_q.cs_n & s2_q.pause_n & ~paused_q
                          & (state_q == ST_RDAT || state_q == ST_SRD);
            paused_out <= paused_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write path: holding register and two-entry skid buffer

    assign push = pend_v_q & ~skid_v_q;
    assign pop  = wr_valid_out & wr_ready_in;

    // A byte waits here while the buffer is full; the next must not arrive first
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            pend_v_q <= 1'b0;
            pend_w_q <= '0;
        end else if (wr_take) begin
            pend_v_q <= 1'b1;
            pend_w_q <= '{addr: addr_q, data: byte_nx};
        end else if (push) begin
            pend_v_q <= 1'b0;
        end
    end

    // Head and skid entries; every output comes straight from a register
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            wr_valid_out <= 1'b0;
            wr_word_out  <= '0;
            skid_v_q     <= 1'b0;
            skid_w_q     <= '0;
        end else if (pop || !wr_valid_out) begin
            if (skid_v_q) begin
                wr_valid_out <= 1'b1;
                wr_word_out  <= skid_w_q;
                skid_v_q     <= 1'b0;
            end else begin
                wr_valid_out <= push;
                if (push) begin
                    wr_word_out <= pend_w_q;
                end
            end
        end else if (push) begin
            skid_v_q <= 1'b1;
            skid_w_q <= pend_w_q;
        end
    end

    // standby only once select is high and all writes have drained
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            standby_out <= 1'b1;
        end else begin
            standby_out <= s2_q.cs_n & ~pend_v_q & ~skid_v_q & ~(wr_valid_out & ~pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_so_hiz_cs: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        s2_q.cs_n |=> !so_oe_out) else $error("output driven while deselected");
    chk_so_hiz_pause: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !s2_q.pause_n |=> !so_oe_out) else $error("output driven with pause low");
    chk_paused_quiet: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (paused_q && !s2_q.cs_n) |=> $stable(bit_cnt_q) && $stable(so_out))
        else $error("link moved while paused");
    chk_so_on_fall: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        ($changed(so_out) && !$past(cs_rise)) |-> $past(sck_fall))
        else $error("output changed without clock fall");
    chk_cnt_on_rise: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        ($changed(bit_cnt_q) && !$past(cs_rise)) |-> $past(sck_rise))
        else $error("bit taken without clock rise");
    chk_pause_now: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (!s2_q.cs_n && !s2_q.pause_n && !s2_q.sck) |=> paused_q)
        else $error("pause not entered with clock low");
    chk_pause_defer: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (!paused_q && !s2_q.pause_n && s2_q.sck && s3_q.sck) |=> !paused_q)
        else $error("pause entered before clock fall");
    chk_pause_keeps: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (paused_q && !s2_q.cs_n) |=> $stable(state_q) ##1 $stable(addr_q) || !paused_q)
        else $error("sequence state lost in pause");
    chk_write_finish: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (pend_v_q || skid_v_q) |=> !standby_out) else $error("standby before write done");
    chk_deselect_idle: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        cs_rise |=> state_q == ST_CMD && bit_cnt_q == 4'h0)
        else $error("partial command survived deselect");
    chk_read_request: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (act_rise && state_q == ST_ADDR && bit_cnt_q == ADDR_LAST && cmd_q == CMD_MEM_READ)
        |=> rd_req_out && rd_addr_out == $past(addr_nx[ADDR_W-1:0]))
        else $error("read address not issued");

endmodule : ssl_link

// file: logic/ssl_pkg.sv
// Package for the serial memory link controller: command codes, field widths,
// reset values and the carrier types shared by the link logic.
// Assumes one system clock far faster than the serial clock on the pins.

package ssl_pkg;

    localparam int BYTE_W = 8;
    localparam int ADDR_W = 15;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [3:0] ADDR_LAST = 4'hF;

    localparam logic [7:0] CMD_MEM_READ  = 8'h03;
    localparam logic [7:0] CMD_MEM_WRITE = 8'h02;
    localparam logic [7:0] status_read_cmd  = 8'h05;
    localparam logic [7:0] status_write_cmd = 8'h01;

    localparam logic [7:0] STATUS_RST = 8'h00;

    // Pin bundle carried through the synchroniser
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic pause_n;
    } ssl_pins_t;

    localparam ssl_pins_t PINS_RST = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, pause_n: 1'b1};

    // One written byte with its array address
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } ssl_wr_word_t;

    typedef enum logic [6:0] {
        ST_CMD  = 7'b0000001,
        ST_ADDR = 7'b0000010,
        ST_RDAT = 7'b0000100,
        ST_WDAT = 7'b0001000,
        ST_SRD  = 7'b0010000,
        ST_SWR  = 7'b0100000,
        ST_SKIP = 7'b1000000
    } ssl_state_t;

endpackage : ssl_pkg

// file: verification/ssl_spi_ctrl_model.sv
// Controller-side model of the serial memory link: drives select, clock,
// data and pause. Assumes the bench calls its tasks and supplies the system
// clock, on whose falling edge every pin change lands; the clock idles low.
`timescale 1ns/1ps

module ssl_spi_ctrl_model (
    input  wire logic clk_in,
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      si_out,
    output logic      pause_n_out,
    input  wire logic so_in
);
    // Time of the next scheduled pin change, in ns
    real t_nx = 0.0;

    ////////////////////////////////////////////////////////////////////////
    // Idle pins: deselected, clock low, pause released
    // start deselected with pause high
    initial begin
        cs_n_out    = 1'b1;
        sck_out     = 1'b0;
        si_out      = 1'b0;
        pause_n_out = 1'b1;
    end

    // Drive all pins, then hold for half a 125 ns serial period; each change
    // lands on a system clock fall, so it never races the sampling edge
    task automatic pins(input logic c, input logic k, input logic d, input logic p);
        cs_n_out    = c;
        sck_out     = k;
        si_out      = d;
        pause_n_out = p;
        // Restart the schedule after an idle gap so edges never bunch up
        if (t_nx < $realtime - 4.0) t_nx = $realtime;
        t_nx = t_nx + 62.5;
        for (int i = 0; i < 20 && $realtime < t_nx; i++) @(negedge clk_in);
    endtask : pins

    // data set while clock low, reply taken late in the high phase
    task automatic xbit(input logic d, output logic r);
        pins(1'b0, 1'b0, d, 1'b1);
        pins(1'b0, 1'b1, d, 1'b1);
        r = so_in;
    endtask : xbit

    task automatic xbyte(input logic [7:0] d, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r[i]);
        end
    endtask : xbyte

    // select with the clock low before any command
    task automatic sel();
        pins(1'b0, 1'b0, si_out, 1'b1);
    endtask : sel

    // clock low first, then deselect; data line flips so no stale level
    task automatic desel();
        pins(1'b0, 1'b0, ~si_out, 1'b1);
        pins(1'b1, 1'b0, ~si_out, 1'b1);
    endtask : desel
endmodule : ssl_spi_ctrl_model

// file: verification/tb.sv
// Self-checking bench for the serial memory link controller.
// Assumes the controller model drives the pins and this bench plays memory.
`timescale 1ns/1ps

module tb;
    import ssl_pkg::*;
    logic               sys_clk_in;
    logic               reset_in;
    logic               cs_n, sck, si, pause_n, so_pin;
    logic               so_out, so_oe_out, standby_out, paused_out, rd_req_out;
    logic               wr_valid_out;
    logic               rd_valid_in = 1'b0;
    logic               wr_ready_in = 1'b0;
    logic               rdy_en      = 1'b0;
    logic [ADDR_W-1:0]  rd_addr_out;
    logic [BYTE_W-1:0]  rd_data_in  = 8'h00;
    logic [BYTE_W-1:0]  status_out, rx, d;
    logic [BYTE_W-1:0]  wd [3];
    logic [15:0]        a;
    ssl_wr_word_t       wr_word_out;
    ssl_wr_word_t       wq [$];
    int                 fail_count, n_checks;

    ssl_link dut_u (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .cs_n_in(cs_n),
        .sck_in(sck), .si_in(si), .pause_n_in(pause_n), .so_out(so_out),
        .so_oe_out(so_oe_out), .standby_out(standby_out), .paused_out(paused_out),
        .rd_req_out(rd_req_out), .rd_addr_out(rd_addr_out), .rd_valid_in(rd_valid_in),
        .rd_data_in(rd_data_in), .wr_valid_out(wr_valid_out), .wr_word_out(wr_word_out),
        .wr_ready_in(wr_ready_in), .status_out(status_out));
    ssl_spi_ctrl_model m_u (.clk_in(sys_clk_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(si),
        .pause_n_out(pause_n), .so_in(so_pin));

    // Pin level: no pull on the output line, so it floats when released
    assign so_pin = so_oe_out ? so_out : 1'bz;

    // 250 MHz system clock
    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory stand-in: answers each fetch at once, consumer stalls at random
    function automatic logic [7:0] memf(input logic [ADDR_W-1:0] x);
        return x[7:0] ^ {1'b0, x[14:8]} ^ 8'hA5;
    endfunction : memf

    always @(negedge sys_clk_in) begin
        rd_valid_in <= rd_req_out;
        rd_data_in  <= memf(rd_addr_out);
        wr_ready_in <= rdy_en & 1'($urandom_range(1, 0));
    end

    // Collect words as the consumer takes them
    always @(posedge sys_clk_in) begin
        if (!reset_in && wr_valid_out === 1'b1 && wr_ready_in) wq.push_back(wr_word_out);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_bit(input string n, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    task automatic chk_val(input string n, input logic [22:0] e, input logic [22:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_val

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report

    task automatic clks(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : clks

    // Select, confirm the link woke up, send the instruction byte
    task automatic start(input logic [7:0] c);
        m_u.sel();
        chk_bit("standby selected", 1'b0, standby_out);
        m_u.xbyte(c, rx);
    endtask : start

    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset_in   = 1'b1;
        fail_count = 0;
        n_checks   = 0;
        void'($urandom(49));
        clks(3);
        reset_in = 1'b0;
        clks(6);
        chk_bit("standby idle", 1'b1, standby_out);
        chk_bit("oe idle", 1'b0, so_oe_out);
        // Status byte written, then read back twice in one selection
        d = 8'($urandom);
        start(status_write_cmd);
        m_u.xbyte(d, rx);
        m_u.desel();
        chk_val("status reg", 23'(d), 23'(status_out));
        start(status_read_cmd);
        repeat (2) begin
            m_u.xbyte(8'h00, rx);
            chk_val("status serial", 23'(d), 23'(rx));
        end
        m_u.desel();
        chk_bit("oe deselected", 1'b0, so_oe_out);
        // A cut-short read and an unknown code must both leave no trace
        start(CMD_MEM_READ);
        m_u.xbyte(8'h12, rx);
        m_u.desel();
        start(8'hFF);
        m_u.xbyte(8'h00, rx);
        chk_bit("oe unknown code", 1'b0, so_oe_out);
        m_u.desel();
        start(status_read_cmd);
        m_u.xbyte(8'h00, rx);
        m_u.desel();
        chk_val("fresh command", 23'(d), 23'(rx));
        for (int i = 0; i < 2; i++) begin
            // Top address first, so the 15-bit wrap is exercised
            a     = (i == 0) ? 16'hFFFF : 16'($urandom);
            wd[0] = 8'($urandom);
            wd[1] = ~wd[0];
            wd[2] = wd[0] ^ 8'h3C;
            start(CMD_MEM_WRITE);
            m_u.xbyte(a[15:8], rx);
            m_u.xbyte(a[7:0], rx);
            m_u.xbyte(wd[0], rx);
            for (int b = 7; b >= 3; b--) m_u.xbit(wd[1][b], rx[0]);
            // Pause dropped while the clock is high waits for the fall
            m_u.pins(1'b0, 1'b1, wd[1][3], 1'b0);
            chk_bit("pause deferred", 1'b0, paused_out);
            m_u.pins(1'b0, 1'b0, wd[1][3], 1'b0);
            chk_bit("pause at fall", 1'b1, paused_out);
            m_u.pins(1'b0, 1'b1, ~wd[1][2], 1'b0);
            m_u.pins(1'b0, 1'b0, ~wd[1][2], 1'b0);
            m_u.pins(1'b0, 1'b0, wd[1][2], 1'b1);
            for (int b = 2; b >= 0; b--) m_u.xbit(wd[1][b], rx[0]);
            m_u.xbyte(wd[2], rx);
            m_u.desel();
            clks(20);
            chk_bit("standby write pending", 1'b0, standby_out);
            chk_bit("buffer holds", 1'b1, wr_valid_out);
            rdy_en = 1'b1;
            for (int t = 0; t < 200 && standby_out !== 1'b1; t++) clks(1);
            rdy_en = 1'b0;
            if (standby_out !== 1'b1) begin
                fail_count++;
                $display("ERROR standby drain expected 1 seen %b", standby_out);
                final_report();
            end
            chk_val("word count", 23'd3, 23'(wq.size()));
            for (int j = 0; j < 3 && wq.size() > 0; j++)
                chk_val("write word", {a[14:0] + 15'(j), wd[j]}, wq.pop_front());
            // Read burst with an immediate pause between bytes
            start(CMD_MEM_READ);
            m_u.xbyte(a[15:8], rx);
            m_u.xbyte(a[7:0], rx);
            m_u.xbyte(8'h00, rx);
            chk_val("read byte0", 23'(memf(a[14:0])), 23'(rx));
            m_u.pins(1'b0, 1'b0, 1'b1, 1'b1);
            m_u.pins(1'b0, 1'b0, 1'b1, 1'b0);
            chk_bit("oe paused", 1'b0, so_oe_out);
            chk_bit("pause at once", 1'b1, paused_out);
            m_u.pins(1'b0, 1'b1, 1'b0, 1'b0);
            m_u.pins(1'b0, 1'b0, 1'b0, 1'b0);
            m_u.pins(1'b0, 1'b0, 1'b1, 1'b1);
            m_u.xbyte(8'h00, rx);
            chk_val("read byte1", 23'(memf(a[14:0] + 15'h1)), 23'(rx));
            m_u.desel();
        end
        final_report();
    end
endmodule : tb
